// ---- hw/ras_top.v ----
// Return address stack with pointer, full and underflow flags, top-of-stack
// access, program counter low byte writes and the fast register shadow.
// Assumes an AXI4-Lite master for software and a core sequencer that raises
// at most one of push, pop, software push, software pop, low byte write per cycle.
`timescale 1ns/100ps
`include "ras_defines.vh"
module ras_top (
    input  wire        i_clk_sys,
    input  wire        i_nrst,
    input  wire        i_dev_reset,
    input  wire        i_overflow_reset_en,
    input  wire [20:0] i_pc,
    input  wire        i_hw_push,
    input  wire        i_hw_pop,
    input  wire        i_sw_push,
    input  wire        i_sw_pop,
    input  wire        i_pcl_wr,
    input  wire [7:0]  i_pcl_data,
    input  wire        i_intr_vector,
    input  wire        i_fast_call,
    input  wire        i_fast_return,
    input  wire [7:0]  i_status,
    input  wire [7:0]  i_working,
    input  wire [7:0]  i_bank,
    output reg         o_pc_load,
    output reg  [20:0] o_pc_value,
    output reg         o_device_reset,
    output reg  [4:0]  o_stack_ptr,
    output wire        o_shadow_restore,
    output wire [7:0]  o_status,
    output wire [7:0]  o_working,
    output wire [7:0]  o_bank,
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready
);

    // ------------------------------------------------------------------------
    // Address decoder
    // ------------------------------------------------------------------------
    function [2:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `RAS_OFF_PTR:         reg_sel = `RAS_SEL_PTR;
                `RAS_OFF_TOP_LOW:     reg_sel = `RAS_SEL_TOP_LOW;
                `RAS_OFF_TOP_HIGH:    reg_sel = `RAS_SEL_TOP_HIGH;
                `RAS_OFF_TOP_UPPER:   reg_sel = `RAS_SEL_TOP_UPPER;
                `RAS_OFF_HIGH_LATCH:  reg_sel = `RAS_SEL_HIGH_LATCH;
                `RAS_OFF_UPPER_LATCH: reg_sel = `RAS_SEL_UPPER_LATCH;
                `RAS_OFF_PC_LOW:      reg_sel = `RAS_SEL_PC_LOW;
                default:              reg_sel = `RAS_SEL_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [20:0] stack_mem [1:`RAS_DEPTH];
    reg  [4:0]  ptr_reg;
    reg         stack_full_flag;
    reg         stack_underflow_flag;
    reg  [7:0]  pc_high_latch;
    reg  [4:0]  pc_upper_latch;
    reg         aw_held_reg;
    reg         w_held_reg;
    reg  [7:0]  aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;

    reg  [4:0]  ptr_next;
    reg         full_set;
    reg         unf_set;
    reg         mem_we;
    reg  [4:0]  mem_wa;
    reg  [20:0] mem_wd;
    reg         pc_load_next;
    reg  [20:0] pc_value_next;
    reg         dev_rst_next;

    wire [20:0] top_entry;
    wire [20:0] pc_plus2;
    wire        push_any;
    wire        core_busy;
    wire        axi_exec;
    wire [2:0]  wr_sel;
    wire        wr_lane0;
    wire        clr_full;
    wire        clr_unf;
    wire        ar_hs;
    wire        aw_hs;
    wire        w_hs;

    // Position zero has no storage behind it and reads as zero.
    assign top_entry = (ptr_reg == `RAS_PTR_RESET) ? 21'h000000 : stack_mem[ptr_reg];
    assign pc_plus2  = i_pc + `RAS_PC_STEP;
    assign push_any  = i_hw_push | i_sw_push;
    // Software writes wait while the core touches the stack or program counter.
    assign core_busy = push_any | i_hw_pop | i_sw_pop | i_pcl_wr | i_dev_reset | o_device_reset;
    assign axi_exec  = aw_held_reg & w_held_reg & ~o_bvalid & ~core_busy;
    assign wr_sel    = reg_sel(aw_addr_reg);
    assign wr_lane0  = w_strb_reg[0];
    assign clr_full  = axi_exec & (wr_sel == `RAS_SEL_PTR) & wr_lane0
                       & ~w_data_reg[`RAS_BIT_FULL];
    assign clr_unf   = axi_exec & (wr_sel == `RAS_SEL_PTR) & wr_lane0
                       & ~w_data_reg[`RAS_BIT_UNDERFLOW];
    assign aw_hs     = i_awvalid & o_awready;
    assign w_hs      = i_wvalid & o_wready;
    assign ar_hs     = i_arvalid & o_arready;

    // ------------------------------------------------------------------------
    // Stack sequencing
    // ------------------------------------------------------------------------
    always @* begin
        ptr_next      = ptr_reg;
        full_set      = 1'b0;
        unf_set       = 1'b0;
        mem_we        = 1'b0;
        mem_wa        = ptr_reg;
        mem_wd        = top_entry;
        pc_load_next  = 1'b0;
        pc_value_next = o_pc_value;
        dev_rst_next  = 1'b0;
        if (i_dev_reset | o_device_reset) begin
            ptr_next = `RAS_PTR_RESET;
        end else if (push_any) begin
            if (ptr_reg == `RAS_PTR_MAX) begin
                full_set     = 1'b1;
                dev_rst_next = i_overflow_reset_en;
            end else begin
                ptr_next = ptr_reg + 5'h01;
                mem_we   = 1'b1;
                mem_wa   = ptr_reg + 5'h01;
                mem_wd   = i_pc;
                if (ptr_reg == `RAS_PTR_MAX - 5'h01) begin
                    full_set = 1'b1;
                    if (i_overflow_reset_en) begin
                        mem_wd       = pc_plus2;
                        dev_rst_next = 1'b1;
                    end
                end
            end
        end else if (i_hw_pop) begin
            pc_load_next = 1'b1;
            if (ptr_reg == `RAS_PTR_RESET) begin
                pc_value_next = 21'h000000;
                unf_set       = 1'b1;
                dev_rst_next  = i_overflow_reset_en;
            end else begin
                pc_value_next = top_entry;
                ptr_next      = ptr_reg - 5'h01;
            end
        end else if (i_sw_pop) begin
            if (ptr_reg == `RAS_PTR_RESET) begin
                unf_set      = 1'b1;
                dev_rst_next = i_overflow_reset_en;
            end else begin
                ptr_next = ptr_reg - 5'h01;
            end
        end else if (i_pcl_wr) begin
            // The low bit is forced to zero so an odd offset cannot misalign.
            pc_load_next  = 1'b1;
            pc_value_next = {pc_upper_latch, pc_high_latch, i_pcl_data[7:1], 1'b0};
        end else if (axi_exec & wr_lane0) begin
            case (wr_sel)
                `RAS_SEL_PTR: begin
                    ptr_next = w_data_reg[4:0];
                end
                `RAS_SEL_TOP_LOW: begin
                    mem_we = (ptr_reg != `RAS_PTR_RESET);
                    mem_wd = {top_entry[20:8], w_data_reg[7:0]};
                end
                `RAS_SEL_TOP_HIGH: begin
                    mem_we = (ptr_reg != `RAS_PTR_RESET);
                    mem_wd = {top_entry[20:16], w_data_reg[7:0], top_entry[7:0]};
                end
                `RAS_SEL_TOP_UPPER: begin
                    mem_we = (ptr_reg != `RAS_PTR_RESET);
                    mem_wd = {w_data_reg[4:0], top_entry[15:0]};
                end
                `RAS_SEL_PC_LOW: begin
                    pc_load_next  = 1'b1;
                    pc_value_next = {pc_upper_latch, pc_high_latch, w_data_reg[7:1], 1'b0};
                end
                default: begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    always @(posedge i_clk_sys) begin
        if (mem_we) begin
            stack_mem[mem_wa] <= mem_wd;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            ptr_reg              <= `RAS_PTR_RESET;
            stack_full_flag      <= 1'b0;
            stack_underflow_flag <= 1'b0;
            o_pc_load            <= 1'b0;
            o_pc_value           <= 21'h000000;
            o_device_reset       <= 1'b0;
            o_stack_ptr          <= `RAS_PTR_RESET;
        end else begin
            ptr_reg              <= ptr_next;
            o_stack_ptr          <= ptr_next;
            // A flag set in the same cycle as a software clear stays set.
            stack_full_flag      <= full_set | (stack_full_flag & ~clr_full);
            stack_underflow_flag <= unf_set | (stack_underflow_flag & ~clr_unf);
            o_pc_load            <= pc_load_next;
            o_pc_value           <= pc_value_next;
            o_device_reset       <= dev_rst_next;
        end
    end

    // ------------------------------------------------------------------------
    // Program counter latches
    // ------------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            pc_high_latch  <= 8'h00;
            pc_upper_latch <= 5'h00;
        end else if (axi_exec & wr_lane0) begin
            if (wr_sel == `RAS_SEL_HIGH_LATCH) begin
                pc_high_latch <= w_data_reg[7:0];
            end
            if (wr_sel == `RAS_SEL_UPPER_LATCH) begin
                pc_upper_latch <= w_data_reg[4:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            o_awready   <= 1'b0;
            o_wready    <= 1'b0;
            o_bvalid    <= 1'b0;
            o_bresp     <= `RAS_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
                o_awready   <= 1'b0;
            end else if (axi_exec) begin
                aw_held_reg <= 1'b0;
            end else if (!aw_held_reg && !o_bvalid) begin
                o_awready <= 1'b1;
            end
            if (w_hs) begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                o_wready   <= 1'b0;
            end else if (axi_exec) begin
                w_held_reg <= 1'b0;
            end else if (!w_held_reg && !o_bvalid) begin
                o_wready <= 1'b1;
            end
            if (axi_exec) begin
                o_bvalid <= 1'b1;
                o_bresp  <= (wr_sel == `RAS_SEL_NONE) ? `RAS_RESP_SLVERR : `RAS_RESP_OKAY;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `RAS_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rresp   <= `RAS_RESP_OKAY;
                case (reg_sel(i_araddr))
                    `RAS_SEL_PTR:         o_rdata <= {24'h000000, stack_full_flag,
                                                      stack_underflow_flag, 1'b0, ptr_reg};
                    `RAS_SEL_TOP_LOW:     o_rdata <= {24'h000000, top_entry[7:0]};
                    `RAS_SEL_TOP_HIGH:    o_rdata <= {24'h000000, top_entry[15:8]};
                    `RAS_SEL_TOP_UPPER:   o_rdata <= {27'h0000000, top_entry[20:16]};
                    `RAS_SEL_HIGH_LATCH:  o_rdata <= {24'h000000, pc_high_latch};
                    `RAS_SEL_UPPER_LATCH: o_rdata <= {27'h0000000, pc_upper_latch};
                    `RAS_SEL_PC_LOW:      o_rdata <= {24'h000000, i_pc[7:1], 1'b0};
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= `RAS_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end else if (!o_rvalid) begin
                o_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Fast register shadow
    // ------------------------------------------------------------------------
    ras_shadow u_shadow (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_save    (i_intr_vector | i_fast_call),
        .i_restore (i_fast_return),
        .i_status  (i_status),
        .i_working (i_working),
        .i_bank    (i_bank),
        .o_restore (o_shadow_restore),
        .o_status  (o_status),
        .o_working (o_working),
        .o_bank    (o_bank)
    );

endmodule

// ---- hw/ras_defines.vh ----
// Constants for the return address stack: register offsets, field positions,
// reset values and stack geometry.
// Assumes inclusion by bare name from each design file of the block that uses its macros.
//
// Notes on behaviour
// - Stack pointer holds 0 to 31 in a five-bit field.
// - Push increments pointer then writes; pop reads entry then decrements.
// - Every reset clears the pointer; position zero holds no entry.
// - Software reads and writes the pointer field through its register.
// - Full flag sets after 31 pushes without an intervening pop.
// - With reset enabled, 31st push stores PC plus 2, sets full, resets device.
// - With reset disabled, 31st push sets full, pointer 31; further pushes do nothing.
// - Pop at pointer zero returns zero to PC, sets underflow, pointer stays zero.
// - With reset disabled, underflow vectoring to zero is no reset; other registers keep their values.
// - Full bit 7 and underflow bit 6 stay set until software or power-on clears.
// - Full or underflow sets its flag; resets device only when enable set.
// - Software push increments pointer and stores current PC in new entry.
// - Software pop only decrements pointer; previous entry becomes top.
// - Pointer register: full bit 7, underflow bit 6, bit 5 zero, pointer bits 4-0.
// - Top-of-stack register writes modify the entry at the current pointer.
// - One-level hidden shadow of status, working, bank select loaded on interrupt.
// - Every interrupt source loads the shadow regardless of priority.
// - Fast return from interrupt restores shadowed values to live registers.
// - High-priority interrupt during low-priority service overwrites the shadow.
// - Fast call saves status, working, bank select; fast return restores them.
// - Any write to PC low byte also loads upper and high latches into PC.
// - Stack storage is 31 entries of 21 bits, apart from other memories.
`ifndef RAS_DEFINES_VH
`define RAS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register map, byte addresses on the AXI4-Lite bus
// ----------------------------------------------------------------------------
`define RAS_ADDR_W          8
`define RAS_OFF_PTR         8'h00
`define RAS_OFF_TOP_LOW     8'h04
`define RAS_OFF_TOP_HIGH    8'h08
`define RAS_OFF_TOP_UPPER   8'h0c
`define RAS_OFF_HIGH_LATCH  8'h10
`define RAS_OFF_UPPER_LATCH 8'h14
`define RAS_OFF_PC_LOW      8'h18

// Register select codes returned by the address decoder.
`define RAS_SEL_NONE        3'h0
`define RAS_SEL_PTR         3'h1
`define RAS_SEL_TOP_LOW     3'h2
`define RAS_SEL_TOP_HIGH    3'h3
`define RAS_SEL_TOP_UPPER   3'h4
`define RAS_SEL_HIGH_LATCH  3'h5
`define RAS_SEL_UPPER_LATCH 3'h6
`define RAS_SEL_PC_LOW      3'h7

// ----------------------------------------------------------------------------
// Fields and geometry
// ----------------------------------------------------------------------------
`define RAS_BIT_FULL        7
`define RAS_BIT_UNDERFLOW   6
`define RAS_PTR_W           5
`define RAS_PC_W            21
`define RAS_DEPTH           31
`define RAS_PTR_MAX         5'h1f
`define RAS_PTR_RESET       5'h00
`define RAS_UPPER_W         5
`define RAS_PC_STEP         21'h000002
`define RAS_RESP_OKAY       2'h0
`define RAS_RESP_SLVERR     2'h2

`endif

// ---- hw/ras_shadow.v ----
// One-level fast register shadow for status, working and bank select values.
// Assumes the sequencer raises save and restore as one-cycle pulses.
`timescale 1ns/100ps
module ras_shadow (
    input  wire       i_clk_sys,
    input  wire       i_nrst,
    input  wire       i_save,
    input  wire       i_restore,
    input  wire [7:0] i_status,
    input  wire [7:0] i_working,
    input  wire [7:0] i_bank,
    output reg        o_restore,
    output reg  [7:0] o_status,
    output reg  [7:0] o_working,
    output reg  [7:0] o_bank
);

    reg [7:0] status_reg;
    reg [7:0] working_reg;
    reg [7:0] bank_reg;

    // ------------------------------------------------------------------------
    // Shadow storage
    // ------------------------------------------------------------------------
    // Each save overwrites the single level, so a nested entry loses the
    // outer values; software must keep them itself in that case.
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            status_reg  <= 8'h00;
            working_reg <= 8'h00;
            bank_reg    <= 8'h00;
        end else if (i_save) begin
            status_reg  <= i_status;
            working_reg <= i_working;
            bank_reg    <= i_bank;
        end
    end

    // ------------------------------------------------------------------------
    // Restore path
    // ------------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_restore <= 1'b0;
            o_status  <= 8'h00;
            o_working <= 8'h00;
            o_bank    <= 8'h00;
        end else begin
            o_restore <= i_restore;
            if (i_restore) begin
                o_status  <= status_reg;
                o_working <= working_reg;
                o_bank    <= bank_reg;
            end
        end
    end

endmodule

// ---- verification/ras_top_properties.sv ----
// Checker for ras_top: pointer steps, underflow, device reset requests, shadow restore.
// Assumes one clock domain; bound to every ras_top below.
`timescale 1ns/100ps
module ras_top_properties (
    input wire        i_clk_sys,
    input wire        i_nrst,
    input wire        i_dev_reset,
    input wire        i_overflow_reset_en,
    input wire        i_hw_push,
    input wire        i_hw_pop,
    input wire        i_sw_push,
    input wire        i_sw_pop,
    input wire        i_fast_return,
    input wire        o_pc_load,
    input wire [20:0] o_pc_value,
    input wire        o_device_reset,
    input wire [4:0]  o_stack_ptr,
    input wire        o_shadow_restore
);
    wire blk = i_dev_reset | o_device_reset;
    wire psh = !blk & (i_hw_push | i_sw_push);
    wire pop = !blk & !psh & (i_hw_pop | i_sw_pop);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    push_step_a: assert property (psh && o_stack_ptr < 5'h1e
        |=> o_stack_ptr == $past(o_stack_ptr) + 5'h01) else $error("push did not step");
    pop_step_a: assert property (pop && o_stack_ptr != 5'h00
        |=> o_stack_ptr == $past(o_stack_ptr) - 5'h01) else $error("pop did not step");
    sw_pop_a: assert property (pop && !i_hw_pop |=> !o_pc_load)
        else $error("software pop loaded pc");
    under_pc_a: assert property (pop && i_hw_pop && o_stack_ptr == 5'h00
        |=> o_pc_load && o_pc_value == 21'h0 && o_stack_ptr == 5'h00) else $error("bad underflow");
    full_hold_a: assert property (psh && o_stack_ptr == 5'h1f && !i_overflow_reset_en
        |=> o_stack_ptr == 5'h1f) else $error("push past full moved pointer");
    ptr_clear_a: assert property (blk |=> o_stack_ptr == 5'h00)
        else $error("reset kept pointer");
    rst_pulse_a: assert property (o_device_reset |=> !o_device_reset)
        else $error("reset request too long");
    rst_cause_a: assert property ($rose(o_device_reset) |-> $past(i_overflow_reset_en))
        else $error("reset request while disabled");
    under_rst_a: assert property (pop && o_stack_ptr == 5'h00 && i_overflow_reset_en
        |=> o_device_reset) else $error("underflow without reset request");
    restore_a: assert property (i_fast_return |=> o_shadow_restore)
        else $error("no shadow restore");
endmodule
bind ras_top ras_top_properties chk_u (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_dev_reset(i_dev_reset), .i_overflow_reset_en(i_overflow_reset_en),
    .i_hw_push(i_hw_push), .i_hw_pop(i_hw_pop), .i_sw_push(i_sw_push), .i_sw_pop(i_sw_pop),
    .i_fast_return(i_fast_return), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
    .o_device_reset(o_device_reset), .o_stack_ptr(o_stack_ptr),
    .o_shadow_restore(o_shadow_restore));

// ---- verification/ras_core_model.sv ----
// Core sequencer model: holds the program counter and follows pc loads.
// Assumes each push pulse ends one instruction, so the pc moves one word on.
`timescale 1ns/100ps
module ras_core_model #(parameter [20:0] START = 21'h001000) (
    input  wire        i_clk_sys,
    input  wire        i_nrst,
    input  wire        i_step,
    input  wire        i_pc_load,
    input  wire [20:0] i_pc_value,
    output reg  [20:0] o_pc
);
    always @(posedge i_clk_sys) begin
        if (!i_nrst)
            o_pc <= START;
        else if (i_pc_load)
            o_pc <= i_pc_value;
        else if (i_step)
            o_pc <= o_pc + 21'h000002;
    end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for ras_top: AXI4-Lite register tasks and core pulse tasks.
// Assumes the core model supplies the pc; bready and rready stay high.
`timescale 1ns/100ps
module tb_top;
    localparam [20:0] ST = 21'h001000;
    localparam [8:0]  DR = 9'h100, PU = 9'h080, PO = 9'h040, SPU = 9'h020, SPO = 9'h010;
    localparam [8:0]  PW = 9'h008, FC = 9'h004, IV = 9'h002, FR = 9'h001;
    reg         clk = 1'b0, nrst = 1'b0, en = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    reg  [8:0]  ops = 9'h000;
    reg  [23:0] shv = 24'h000000;
    reg  [7:0]  pd = 8'h00, awa = 8'h00, ara = 8'h00;
    reg  [31:0] wd = 32'h00000000, d;
    wire [20:0] pc, pv;
    wire [7:0]  st, wk, bk;
    wire [4:0]  sp;
    wire [31:0] rdat;
    wire [1:0]  bre, rre;
    wire        pl, dro, srs, awr, wrr, bv, arr, rv;
    integer     failures = 0, compares = 0, cyc = 0, k;
    reg  [1:0]  r;
    reg  [20:0] v;
    reg  [4:0]  cp;
    reg         cl, cr, cs;
    ras_top dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_dev_reset(ops[8]),
        .i_overflow_reset_en(en), .i_pc(pc), .i_hw_push(ops[7]), .i_hw_pop(ops[6]),
        .i_sw_push(ops[5]), .i_sw_pop(ops[4]), .i_pcl_wr(ops[3]), .i_pcl_data(pd),
        .i_intr_vector(ops[1]), .i_fast_call(ops[2]), .i_fast_return(ops[0]),
        .i_status(shv[23:16]), .i_working(shv[15:8]), .i_bank(shv[7:0]), .o_pc_load(pl),
        .o_pc_value(pv), .o_device_reset(dro), .o_stack_ptr(sp), .o_shadow_restore(srs),
        .o_status(st), .o_working(wk), .o_bank(bk), .i_awaddr(awa), .i_awvalid(awv),
        .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr),
        .o_bresp(bre), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ara), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdat), .o_rresp(rre), .o_rvalid(rv), .i_rready(1'b1));
    ras_core_model #(.START(ST)) core_u (.i_clk_sys(clk), .i_nrst(nrst),
        .i_step(ops[7] | ops[5]), .i_pc_load(pl), .i_pc_value(pv), .o_pc(pc));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            final_report;
        end
    end
    // ------------------------------------------------------------------------
    // Tasks, each entered just after a rising edge
    // ------------------------------------------------------------------------
    task final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] dt);
        awa <= a;
        wd <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wrr));
        do @(posedge clk); while (!bv);
        r = bre;
    endtask
    task rd(input [7:0] a);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        d = rdat;
        r = rre;
    endtask
    task rc(input [7:0] a, input [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    task rtop(input [20:0] ex);
        reg [31:0] lo, hi;
        rd(8'h04);
        lo = d;
        rd(8'h08);
        hi = d;
        rd(8'h0c);
        chk({d[4:0], hi[7:0], lo[7:0]}, {11'h000, ex});
    endtask
    // The pulse is taken at the first edge; results are captured just after it.
    task op(input [8:0] p);
        ops <= p;
        @(posedge clk);
        ops <= 9'h000;
        #1;
        {cl, cr, cs, cp, v} = {pl, dro, srs, sp, pv};
        @(posedge clk);
    endtask
    // ------------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'h00);
        for (k = 1; k < 32; k = k + 1) begin
            op(PU);
            chk(cp, k);
            if (k == 30) rc(8'h00, 32'h1e);
        end
        rc(8'h00, 32'h9f);
        op(PU);
        chk(cp, 5'h1f);
        rtop(ST + 21'd60);
        op(PO);
        chk({cl, cp, v}, {1'b1, 5'h1e, ST + 21'd60});
        op(SPO);
        chk({cl, cp}, {1'b0, 5'h1d});
        rtop(ST + 21'd56);
        op(SPU);
        rtop(ST + 21'd60);
        wr(8'h04, 32'h44);
        wr(8'h08, 32'h33);
        wr(8'h0c, 32'h0a);
        rtop(21'h0a3344);
        op(PO);
        chk({cl, v}, {1'b1, 21'h0a3344});
        wr(8'h00, 32'h80);
        rc(8'h00, 32'h80);
        wr(8'h10, 32'h12);
        wr(8'h14, 32'h05);
        op(PO);
        chk({cl, cr, cp, v}, {2'b10, 5'h00, 21'h0});
        rc(8'h00, 32'hc0);
        rc(8'h10, 32'h12);
        wr(8'h00, 32'hff);
        rc(8'h00, 32'hdf);
        pd <= 8'h34;
        op(PW);
        chk(v, 21'h051234);
        wr(8'h18, 32'h57);
        chk(pv, 21'h051256);
        rc(8'h18, 32'h56);
        wr(8'h00, 32'h1e);
        en <= 1'b1;
        op(PU);
        chk({cr, cp}, {1'b1, 5'h1f});
        rc(8'h00, 32'h80);
        wr(8'h00, 32'h9f);
        rtop(21'h051258);
        wr(8'h00, 32'h80);
        op(PO);
        chk({cr, v}, {1'b1, 21'h0});
        wr(8'h00, 32'hc5);
        op(DR);
        rc(8'h00, 32'hc0);
        wr(8'h40, 32'h01);
        chk(r, 2'h2);
        rd(8'h40);
        chk({r, d}, {2'h2, 32'h0});
        shv <= 24'h112233;
        op(FC);
        shv <= 24'h000000;
        op(FR);
        chk({cs, st, wk, bk}, {1'b1, 24'h112233});
        shv <= 24'h445566;
        op(IV);
        shv <= 24'h778899;
        op(IV);
        shv <= 24'h000000;
        op(FR);
        chk({cs, st, wk, bk}, {1'b1, 24'h778899});
        final_report;
    end
endmodule
